// [bench/rpm_monitor.sv]
`timescale 1ns/1ps
`include "rpm_consts.svh"
module rpm_monitor #(
    parameter int WDOG_PULSE = `RPM_WDOG_PULSE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // inputs seen
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic supply_ok,
    input wire logic hw_wdog_expire,
    input wire logic arr_wdog_reset,
    input wire logic rst_pin_in,
    input wire logic irq_pending,
    input wire logic ext_irq_pending,
    input wire logic instr_done,
    // outputs watched
    input wire logic rst_pin_oe,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_enable,
    input wire logic core_rst,
    input wire logic fetch_from_zero
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // low cycles of the pin pulse, eight bits are enough for it
    logic [7:0] low_cnt;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            low_cnt <= 8'h00;
        else
            low_cnt <= rst_pin_oe ? 8'h00 : low_cnt + 8'h01;
    end
    // idle: peripherals clocked, cpu frozen
    wire idle_now = periph_clk_en && !cpu_clk_en && !core_rst;
    property p_src_or;
        arr_wdog_reset || rst_pin_in || !supply_ok |-> core_rst;
    endproperty
    a_src_or: assert property (p_src_or) else $error("reset source lost");
    property p_fetch;
        core_rst |-> fetch_from_zero;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch not at zero");
    property p_pulse_start;
        hw_wdog_expire && rst_pin_oe |=> !rst_pin_oe;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("no pulse");
    property p_pulse_len;
        $rose(rst_pin_oe) |-> int'(low_cnt) == WDOG_PULSE;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse length");
    property p_pd_frozen;
        !osc_enable |-> !cpu_clk_en && !periph_clk_en;
    endproperty
    a_pd_frozen: assert property (p_pd_frozen) else $error("clock runs");
    property p_pin_wake;
        rst_pin_in |-> osc_enable;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("pin no wake");
    property p_pd_exit;
        !osc_enable && ext_irq_pending |=> osc_enable;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("irq no wake");
    property p_idle_exit;
        idle_now && irq_pending |-> ##[1:3] cpu_clk_en;
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle stuck");
    property p_idle_stay;
        idle_now && !irq_pending && !ext_irq_pending && !rst_pin_in
            |=> !cpu_clk_en || rst_pin_in;
    endproperty
    a_idle_stay: assert property (p_idle_stay) else $error("idle left");
    property p_pd_entry;
        reg_wr && reg_addr == `RPM_PWR_CTRL_ADDR
            && reg_wdata[`RPM_PDOWN_BIT] && cpu_clk_en && !core_rst
            ##1 instr_done && !ext_irq_pending && !rst_pin_in
            |=> !osc_enable || rst_pin_in;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("no pdown");
    c_pdown: cover property (!osc_enable);
    c_pulse: cover property ($rose(rst_pin_oe));
    c_idle: cover property (idle_now);
endmodule

bind rpm_ctrl rpm_monitor #(.WDOG_PULSE(WDOG_PULSE)) i_rpm_monitor (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .supply_ok,
    .hw_wdog_expire, .arr_wdog_reset, .rst_pin_in, .irq_pending,
    .ext_irq_pending, .instr_done, .rst_pin_oe, .cpu_clk_en,
    .periph_clk_en, .osc_enable, .core_rst, .fetch_from_zero);

// [bench/rpm_partner.sv]
`timescale 1ns/1ps
module rpm_partner (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // bench command: outside party holds the pin
    input wire logic ext_rst,
    // seen from the block
    input wire logic reg_wr,
    input wire logic rst_pin_oe,
    input wire logic rst_pin_out,
    // driven to the block
    output logic instr_done,
    output logic rst_pin_in
);
    // cpu finishes the storing instruction one cycle after the write
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            instr_done <= 1'b0;
        else
            instr_done <= reg_wr;
    end
    // pull-down pin: high only when held outside or driven by the block
    assign rst_pin_in = ext_rst | (~rst_pin_oe & rst_pin_out);
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
`include "rpm_consts.svh"
module tb_top;
    // short power monitor wait keeps the run brief
    localparam int PW = 8;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } rpm_row_t;
    // write, read back, expected word
    rpm_row_t rows [5] = '{
        '{8'h00, 32'h0c, 32'h0c}, '{8'h00, 32'h00, 32'h00},
        '{8'h08, 32'h01, 32'h01}, '{8'h08, 32'h00, 32'h00},
        '{8'h10, 32'hff, 32'h00}};
    logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
    logic supply_ok = 1'b0, xtal_ok = 1'b0, hw_wdog_expire = 1'b0;
    logic arr_wdog_reset = 1'b0, irq_pending = 1'b0, ext_rst = 1'b0;
    logic ext_irq_pending = 1'b0, rst_pin_in, rst_pin_out, rst_pin_oe;
    logic wake_irq, instr_done, cpu_clk_en, periph_clk_en, osc_enable;
    logic core_rst, fetch_from_zero, ram_access_en, port_access_en;
    int num_errors = 0, n_compared = 0, n;
    always #25 clk = ~clk;
    rpm_ctrl #(.PWR_WAIT(PW)) i_rpm_ctrl (.clk, .arst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .supply_ok, .xtal_ok,
        .hw_wdog_expire, .arr_wdog_reset, .rst_pin_in, .rst_pin_out,
        .rst_pin_oe, .irq_pending, .ext_irq_pending, .wake_irq,
        .instr_done, .cpu_clk_en, .periph_clk_en, .osc_enable, .core_rst,
        .fetch_from_zero, .ram_access_en, .port_access_en);
    rpm_partner i_rpm_partner (.clk, .arst_n, .ext_rst, .reg_wr,
        .rst_pin_oe, .rst_pin_out, .instr_done, .rst_pin_in);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("counts: %0d compared, %0d bad", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one edge, then let its updates land
    task tick;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands from the cycle after the strobe until the next read
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick();
        reg_rd <= 1'b0;
        rv = reg_rdata;
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return core_rst;
            1: return cpu_clk_en;
            2: return osc_enable;
            default: return ram_access_en;
        endcase
    endfunction
    // bounded wait; running out counts and ends the run
    task automatic wait_for(input int sel, input logic v);
        int k;
        k = 0;
        while (pick(sel) !== v && k < 2000)
        begin
            tick();
            k++;
        end
        check(k < 2000, 1'b1);
        if (k >= 2000)
            give_verdict();
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) tick();
        check(core_rst, 1'b1);
        supply_ok <= 1'b1;
        xtal_ok <= 1'b1;
        n = 0;
        while (core_rst !== 1'b0 && n < 50)
        begin
            tick();
            n++;
        end
        check(n >= PW && n <= PW + 3, 1'b1);
        $display("reset test done");
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            check(rv, rows[i].e);
        end
        $display("register rows done");
        // divide by two: half the enable pulses
        wr(8'h08, 32'h1);
        n = 0;
        repeat (4)
        begin
            tick();
            n += cpu_clk_en + periph_clk_en;
        end
        check(n, 4);
        wr(8'h08, 32'h0);
        // idle entry, hold, interrupt wake
        wr(8'h00, 32'h1);
        tick();
        check({cpu_clk_en, periph_clk_en}, 2'b01);
        n = 0;
        repeat (5)
        begin
            tick();
            n += cpu_clk_en;
        end
        check(n, 0);
        rd(`RPM_STATUS_ADDR);
        check(rv[`RPM_ST_IDLE_BIT], 1'b1);
        irq_pending <= 1'b1;
        #1;
        check(wake_irq, 1'b1);
        wait_for(1, 1'b1);
        irq_pending <= 1'b0;
        rd(`RPM_PWR_CTRL_ADDR);
        check(rv[`RPM_IDLE_BIT], 1'b0);
        $display("idle test done");
        // both bits: power-down, and no idle afterwards
        wr(8'h00, 32'h3);
        tick();
        check({osc_enable, cpu_clk_en, periph_clk_en}, 3'b000);
        ext_irq_pending <= 1'b1;
        #1;
        check(wake_irq, 1'b1);
        wait_for(2, 1'b1);
        ext_irq_pending <= 1'b0;
        repeat (3) tick();
        check(cpu_clk_en, 1'b1);
        $display("power-down test done");
        // reset pin ends idle, then power-down, without a clock edge
        for (int m = 1; m <= 2; m++)
        begin
            // nothing touches the ports right after the mode request
            wr(8'h00, m);
            tick();
            @(posedge clk);
            ext_rst <= 1'b1;
            #1;
            check({osc_enable, cpu_clk_en}, 2'b11);
            repeat (10) tick();
            check({core_rst, ram_access_en, port_access_en}, 3'b101);
            ext_rst <= 1'b0;
            wait_for(0, 1'b0);
            wait_for(3, 1'b1);
            rd(`RPM_PWR_CTRL_ADDR);
            check(rv[1:0], 2'b00);
        end
        $display("pin wake test done");
        // watchdog pulse on the pin
        @(posedge clk);
        hw_wdog_expire <= 1'b1;
        @(posedge clk);
        hw_wdog_expire <= 1'b0;
        #1;
        check({rst_pin_oe, rst_pin_out}, 2'b01);
        n = 0;
        while (rst_pin_oe === 1'b0 && n < 200)
        begin
            n++;
            tick();
        end
        check(n, `RPM_WDOG_PULSE_CYC);
        wait_for(0, 1'b0);
        // counter-array request is or-ed straight in
        @(posedge clk);
        arr_wdog_reset <= 1'b1;
        tick();
        check(core_rst, 1'b1);
        arr_wdog_reset <= 1'b0;
        wait_for(0, 1'b0);
        $display("watchdog test done");
        give_verdict();
    end
endmodule

// [core/rpm_consts.svh]
`ifndef RPM_CONSTS_SVH
`define RPM_CONSTS_SVH
// register map (index == byte address, one word each)
`define RPM_PWR_CTRL_ADDR 8'h00
`define RPM_STATUS_ADDR 8'h04
`define RPM_CLK_CTRL_ADDR 8'h08
// power control register fields
`define RPM_IDLE_BIT 0
`define RPM_PDOWN_BIT 1
`define RPM_GF0_BIT 2
`define RPM_GF1_BIT 3
// status register fields
`define RPM_ST_RST_BIT 0
`define RPM_ST_IDLE_BIT 1
`define RPM_ST_PDOWN_BIT 2
`define RPM_ST_WAKE_BIT 3
// clock control field
`define RPM_DIV2_BIT 0
// timing counts in clock periods
`define RPM_PWR_WAIT_CYC 1024
`define RPM_WDOG_PULSE_CYC 96
`define RPM_WAKE_GRACE_CYC 4
`endif

// [core/rpm_ctrl.sv]
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "rpm_consts.svh"

module rpm_ctrl #(
    parameter int PWR_WAIT = `RPM_PWR_WAIT_CYC,
    parameter int WDOG_PULSE = `RPM_WDOG_PULSE_CYC,
    parameter int WAKE_GRACE = `RPM_WAKE_GRACE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // reset sources
    input wire logic supply_ok,
    input wire logic xtal_ok,
    input wire logic hw_wdog_expire,
    input wire logic arr_wdog_reset,
    // reset pin, one-way drive: oe low while pulling it high
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    // interrupt logic
    input wire logic irq_pending,
    input wire logic ext_irq_pending,
    output logic wake_irq,
    // cpu side
    input wire logic instr_done,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_enable,
    output logic core_rst,
    output logic fetch_from_zero,
    output logic ram_access_en,
    output logic port_access_en
);
    initial begin
        if (PWR_WAIT < 1 || WDOG_PULSE < 1 || WAKE_GRACE < 1)
            $error("rpm_ctrl: counts must be positive");
        if (PWR_WAIT > 65535 || WDOG_PULSE > 65535 || WAKE_GRACE > 255)
            $error("rpm_ctrl: counts exceed counter width");
    end

    rpm_pkg::rpm_mode_t mode_reg; // current power mode
    logic idle_request_bit_reg; // readable idle request
    logic power_down_request_bit_reg; // readable power-down request
    logic general_flag_zero_reg; // software flag
    logic general_flag_one_reg; // software flag
    logic div2_reg; // clock doubler setting: 1 divides by two
    logic div_phase_reg; // divider toggle
    logic pend_idle_reg; // idle request waiting for instr end
    logic pend_pdown_reg; // power-down request waiting
    logic [15:0] pwr_cnt_reg; // power monitor settle counter
    logic pwr_rst_reg; // power monitor reset request
    logic [15:0] wdog_cnt_reg; // watchdog pulse counter
    logic [7:0] grace_cnt_reg; // wake-by-reset grace counter
    logic wake_seen_reg; // sticky: woke from low power
    logic pwr_ctrl_hit; // write decode
    logic clk_ctrl_hit; // write decode
    rpm_pkg::rpm_rst_src_t src; // bundled reset requests
    logic pin_high; // external reset level
    logic div_tick; // one-cycle enable of the divided clock

    // decode shared by read and write paths
    function automatic logic addr_is(input logic [7:0] a,
        input logic [7:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    assign pwr_ctrl_hit = reg_wr && addr_is(reg_addr, `RPM_PWR_CTRL_ADDR);
    assign clk_ctrl_hit = reg_wr && addr_is(reg_addr, `RPM_CLK_CTRL_ADDR);
    // the pin reads back our own pull too, so watchdog pulses count
    assign pin_high = rst_pin_in;

    // power monitor: reset until supply and crystal valid, then wait
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pwr_cnt_reg <= 16'h0000;
            pwr_rst_reg <= 1'b1;
        end
        else if (!supply_ok || !xtal_ok)
        begin
            // supply fault asserts at once
            pwr_cnt_reg <= 16'h0000;
            pwr_rst_reg <= 1'b1;
        end
        else if (pwr_rst_reg)
        begin
            if (pwr_cnt_reg == 16'(PWR_WAIT - 1))
                pwr_rst_reg <= 1'b0;
            else
                pwr_cnt_reg <= pwr_cnt_reg + 16'h0001;
        end
    end

    // watchdog pulse on the reset pin
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wdog_cnt_reg <= 16'h0000;
        else if (hw_wdog_expire)
            wdog_cnt_reg <= 16'(WDOG_PULSE);
        else if (wdog_cnt_reg != 16'h0000)
            wdog_cnt_reg <= wdog_cnt_reg - 16'h0001;
    end

    // pull the pin while counting; released otherwise
    // reset is high active, so the pulse drives the pin high
    assign rst_pin_out = 1'b1;
    assign rst_pin_oe = (wdog_cnt_reg == 16'h0000);

    // reset combining: a level, so any source holds it
    // a supply or crystal fault resets at once, not one edge later
    assign src.pwr_mon = pwr_rst_reg || !supply_ok || !xtal_ok;
    assign src.hw_wdog = (wdog_cnt_reg != 16'h0000);
    assign src.arr_wdog = arr_wdog_reset;
    assign src.pin = pin_high;
    assign core_rst = |src;

    // wake grace: a reset-pin wake lets the cpu run a few cycles
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            grace_cnt_reg <= 8'h00;
        else if (pin_high && (mode_reg == rpm_pkg::MODE_IDLE ||
            mode_reg == rpm_pkg::MODE_PDOWN))
            grace_cnt_reg <= 8'(WAKE_GRACE);
        else if (grace_cnt_reg != 8'h00)
            grace_cnt_reg <= grace_cnt_reg - 8'h01;
    end

    // mode machine; reset pin level clears modes without a clock edge
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_reg <= rpm_pkg::MODE_RUN;
            pend_idle_reg <= 1'b0;
            pend_pdown_reg <= 1'b0;
            wake_seen_reg <= 1'b0;
        end
        else
        begin
            // read clear first, so a wake in the same cycle wins
            if (addr_is(reg_addr, `RPM_STATUS_ADDR) && reg_rd)
                wake_seen_reg <= 1'b0;
            case (mode_reg)
                rpm_pkg::MODE_RUN:
                begin
                    if (core_rst)
                    begin
                        // any reset drops requests still waiting
                        pend_pdown_reg <= 1'b0;
                        pend_idle_reg <= 1'b0;
                    end
                    else if (pwr_ctrl_hit)
                    begin
                        // power-down wins when both are written
                        pend_pdown_reg <= reg_wdata[`RPM_PDOWN_BIT];
                        pend_idle_reg <= reg_wdata[`RPM_IDLE_BIT] &&
                            !reg_wdata[`RPM_PDOWN_BIT];
                    end
                    else if (instr_done && pend_pdown_reg)
                    begin
                        mode_reg <= rpm_pkg::MODE_PDOWN;
                        pend_pdown_reg <= 1'b0;
                    end
                    else if (instr_done && pend_idle_reg)
                    begin
                        mode_reg <= rpm_pkg::MODE_IDLE;
                        pend_idle_reg <= 1'b0;
                    end
                end
                rpm_pkg::MODE_IDLE:
                begin
                    if (pin_high)
                    begin
                        mode_reg <= rpm_pkg::MODE_WAKE_RST;
                        wake_seen_reg <= 1'b1;
                    end
                    else if (irq_pending)
                    begin
                        // back to run; cpu resumes via its isr
                        mode_reg <= rpm_pkg::MODE_RUN;
                        wake_seen_reg <= 1'b1;
                    end
                end
                rpm_pkg::MODE_PDOWN:
                begin
                    if (pin_high)
                    begin
                        mode_reg <= rpm_pkg::MODE_WAKE_RST;
                        wake_seen_reg <= 1'b1;
                    end
                    else if (ext_irq_pending)
                    begin
                        // never falls into idle afterwards
                        mode_reg <= rpm_pkg::MODE_RUN;
                        wake_seen_reg <= 1'b1;
                    end
                end
                rpm_pkg::MODE_WAKE_RST:
                begin
                    // ends when grace is over and reset has let go
                    if (grace_cnt_reg == 8'h00 && !core_rst)
                        mode_reg <= rpm_pkg::MODE_RUN;
                end
                default:
                    mode_reg <= rpm_pkg::MODE_RUN;
            endcase
        end
    end

    // readable request bits; pin clears them combinationally
    assign idle_request_bit_reg = (mode_reg == rpm_pkg::MODE_IDLE) &&
        !pin_high;
    assign power_down_request_bit_reg =
        (mode_reg == rpm_pkg::MODE_PDOWN) && !pin_high;

    // software flags and clock doubler setting
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            general_flag_zero_reg <= 1'b0;
            general_flag_one_reg <= 1'b0;
            div2_reg <= 1'b0;
        end
        else
        begin
            if (pwr_ctrl_hit)
            begin
                general_flag_zero_reg <= reg_wdata[`RPM_GF0_BIT];
                general_flag_one_reg <= reg_wdata[`RPM_GF1_BIT];
            end
            if (clk_ctrl_hit)
                div2_reg <= reg_wdata[`RPM_DIV2_BIT];
        end
    end

    // divide-by-two enable, independent of the power modes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            div_phase_reg <= 1'b0;
        else
            div_phase_reg <= !div_phase_reg;
    end
    assign div_tick = !div2_reg || div_phase_reg;

    // clock gating: enables freeze state, nothing is cleared
    assign cpu_clk_en = div_tick && (idle_request_bit_reg == 1'b0) &&
        (power_down_request_bit_reg == 1'b0);
    assign periph_clk_en = div_tick && !power_down_request_bit_reg;
    assign osc_enable = !power_down_request_bit_reg;
    assign wake_irq = (mode_reg == rpm_pkg::MODE_IDLE && irq_pending) ||
        (mode_reg == rpm_pkg::MODE_PDOWN && ext_irq_pending);
    assign fetch_from_zero = core_rst;
    // ram locked while a reset wake-up runs, ports stay usable
    assign ram_access_en = (mode_reg != rpm_pkg::MODE_WAKE_RST);
    assign port_access_en = 1'b1;

    // read data, one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            reg_rdata <= 32'h0000_0000;
            if (addr_is(reg_addr, `RPM_PWR_CTRL_ADDR))
            begin
                reg_rdata[`RPM_IDLE_BIT] <= idle_request_bit_reg ||
                    pend_idle_reg;
                reg_rdata[`RPM_PDOWN_BIT] <= power_down_request_bit_reg ||
                    pend_pdown_reg;
                reg_rdata[`RPM_GF0_BIT] <= general_flag_zero_reg;
                reg_rdata[`RPM_GF1_BIT] <= general_flag_one_reg;
            end
            else if (addr_is(reg_addr, `RPM_STATUS_ADDR))
            begin
                reg_rdata[`RPM_ST_RST_BIT] <= core_rst;
                reg_rdata[`RPM_ST_IDLE_BIT] <= idle_request_bit_reg;
                reg_rdata[`RPM_ST_PDOWN_BIT] <= power_down_request_bit_reg;
                reg_rdata[`RPM_ST_WAKE_BIT] <= wake_seen_reg;
            end
            else if (addr_is(reg_addr, `RPM_CLK_CTRL_ADDR))
                reg_rdata[`RPM_DIV2_BIT] <= div2_reg;
        end
    end
endmodule

// [core/rpm_pkg.sv]
package rpm_pkg;
    // power mode states
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_PDOWN,
        MODE_WAKE_RST
    } rpm_mode_t;

    // reset source requests
    typedef struct packed {
        logic pwr_mon;
        logic hw_wdog;
        logic arr_wdog;
        logic pin;
    } rpm_rst_src_t;
endpackage
